// ==== logic/status_record_and_reply_framer.sv ====
`timescale 1ns/1ps
module status_record_and_reply_framer #(
	parameter int unsigned NUM_AXES = frame_pkg::AXIS_MAX,
	parameter int unsigned DECODE_CYCLES = frame_pkg::DECODE_CYCLES_DEF
)(
	// clock and reset
	input logic pclk,
	input logic presetn,
	// apb slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [frame_pkg::APB_AW-1:0] paddr,
	input logic [31:0] pwdata,
	input logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// controller state
	input frame_pkg::gen_in_t gen_in,
	input frame_pkg::plane_in_t [1:0] plane_in,
	input frame_pkg::axis_in_t [frame_pkg::AXIS_MAX-1:0] axis_in,
	// command bytes from host
	input logic rx_valid,
	input logic [7:0] rx_data,
	input logic rx_port,
	output logic rx_ready,
	// reply bytes to host
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_port,
	input logic tx_ready
);
	import frame_pkg::*;

	typedef enum logic [2:0] {ST_RX, ST_ECHO, ST_DECODE, ST_DATA, ST_CR, ST_LF,
		ST_PROMPT} fsm_state_t;

	// recognise the three supported commands, all else is refused
	function automatic cmd_kind_t classify(input logic [7:0] c0, input logic [7:0] c1,
		input logic [7:0] a, input logic [1:0] nc, input logic [1:0] na);
		cmd_kind_t k;
		k = CMD_BAD;
		if (nc == 2'h2)
		begin
			if (c0 == CH_Q && c1 == CH_R && na == 2'h0)
				k = CMD_RECORD;
			else if (c0 == CH_Q && c1 == CH_Z && na == 2'h0)
				k = CMD_GEOMETRY;
			else if (c0 == CH_E && c1 == CH_O && na == 2'h1 && (a == CH_0 || a == CH_1))
				k = CMD_ECHO;
		end
		return k;
	endfunction : classify

	fsm_state_t state_q, state_d;
	cmd_kind_t kind_q, kind_w, kind_d;
	logic [7:0] cmd0_q, cmd1_q, arg_q;
	logic [1:0] nchar_q, narg_q;
	logic term_q, port_q, echo_q, last_ok_q;
	logic [31:0] cnt_q;
	logic [15:0] idx_q, idx_d;
	logic [15:0] acc_q, rej_q;
	logic [10:0] mask_q, present_w, present_q;
	gen_in_t gen_q;
	plane_in_t [1:0] planes_q;
	axis_in_t [AXIS_MAX-1:0] axes_q;
	logic [7:0] rec_byte;
	logic [15:0] rec_len;
	logic tx_valid_q, rx_ready_q, tx_port_q;
	logic [7:0] tx_data_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;

	// stream handshakes and character classes
	wire rx_fire = rx_valid & rx_ready_q;
	wire tx_fire = tx_valid_q & tx_ready;
	wire is_term = (rx_data == CH_CR) || (rx_data == CH_SEMI);
	wire is_space = rx_data == CH_SPACE;
	wire decode_done = (state_q == ST_DECODE) && (cnt_q == 32'h0);
	wire [15:0] data_last = (kind_d == CMD_RECORD) ? rec_len - 16'h1 : 16'(GEO_BYTES - 1);
	wire [31:0] geo_word = {8'(AXIS_BYTES), 8'(PLANE_BYTES), 8'(GEN_BYTES), 8'(NUM_AXES)};
	wire [10:0] axis_exist = 11'((12'h001 << NUM_AXES) - 12'h001);

	// block presence: software mask, axes limited to those fitted
	assign present_w = mask_q & (axis_exist | 11'h700);
	assign kind_w = classify(cmd0_q, cmd1_q, arg_q, nchar_q, narg_q);
	assign kind_d = (state_q == ST_DECODE) ? kind_w : kind_q;
	// record byte selection from the snapshot
	record_byte_source u_record (
		.gen(gen_q),
		.planes(planes_q),
		.axes(axes_q),
		.present(present_q),
		.echo_on(echo_q),
		.index(idx_d),
		.rec_byte(rec_byte),
		.rec_len(rec_len)
	);
	// reply sequencer: echo, decode wait, data, cr, lf, prompt
	always_comb
	begin
		state_d = state_q;
		idx_d = idx_q;
		case (state_q)
			ST_RX:
				if (rx_fire && echo_q)
					state_d = ST_ECHO;
				else if (rx_fire && is_term)
					state_d = ST_DECODE;
			ST_ECHO:
				if (tx_fire)
					state_d = term_q ? ST_DECODE : ST_RX;
			ST_DECODE:
				if (decode_done)
				begin
					idx_d = 16'h0000;
					if (kind_w == CMD_RECORD || kind_w == CMD_GEOMETRY)
						state_d = ST_DATA;
					else
						state_d = ST_PROMPT;
				end
			ST_DATA:
				if (tx_fire)
				begin
					if (idx_q == data_last)
						state_d = ST_CR;
					else
						idx_d = idx_q + 16'h1;
				end
			ST_CR:
				if (tx_fire)
					state_d = ST_LF;
			ST_LF:
				if (tx_fire)
					state_d = ST_PROMPT;
			ST_PROMPT:
				if (tx_fire)
					state_d = ST_RX;
			default:
				state_d = ST_RX;
		endcase
	end
	// byte that the next state puts on the reply stream
	logic [7:0] byte_d;
	logic send_d;
	always_comb
	begin
		byte_d = tx_data_q;
		send_d = 1'b1;
		case (state_d)
			ST_ECHO:
				byte_d = (state_q == ST_RX) ? rx_data : tx_data_q;
			ST_DATA:
				byte_d = (kind_d == CMD_RECORD) ? rec_byte : geo_word[8*idx_d[1:0] +: 8];
			ST_CR:
				byte_d = CH_CR;
			ST_LF:
				byte_d = CH_LF;
			ST_PROMPT:
				byte_d = (kind_d == CMD_BAD) ? CH_QMARK : CH_COLON;
			default:
				send_d = 1'b0;
		endcase
	end

	// state, reply stream and receive ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_RX;
			idx_q <= 16'h0000;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			tx_port_q <= 1'b0;
			rx_ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			idx_q <= idx_d;
			tx_valid_q <= send_d;
			tx_data_q <= byte_d;
			tx_port_q <= rx_fire ? rx_port : port_q;
			rx_ready_q <= state_d == ST_RX;
		end
	end

	// command parsing: two letters, then one argument character
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd0_q <= 8'h00;
			cmd1_q <= 8'h00;
			arg_q <= 8'h00;
			nchar_q <= 2'h0;
			narg_q <= 2'h0;
			term_q <= 1'b0;
			port_q <= 1'b0;
		end
		else if (rx_fire)
		begin
			term_q <= is_term;
			port_q <= rx_port;
			if (!is_term && !is_space)
			begin
				if (nchar_q == 2'h0)
					cmd0_q <= rx_data;
				else if (nchar_q == 2'h1)
					cmd1_q <= rx_data;
				else if (narg_q == 2'h0)
					arg_q <= rx_data;
				if (nchar_q != 2'h2)
					nchar_q <= nchar_q + 2'h1;
				else if (narg_q != 2'h2)
					narg_q <= narg_q + 2'h1;
			end
		end
		else if (decode_done)
		begin
			nchar_q <= 2'h0;
			narg_q <= 2'h0;
		end
	end

	// decode wait counter, started by the terminator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= 32'h0;
		else if (rx_fire && is_term)
			cnt_q <= 32'(DECODE_CYCLES - 1);
		else if (state_q == ST_DECODE && cnt_q != 32'h0)
			cnt_q <= cnt_q - 32'h1;
	end

	// freeze the controller state when a command ends
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gen_q <= '0;
			planes_q <= '0;
			axes_q <= '0;
			present_q <= 11'h000;
		end
		else if (rx_fire && is_term)
		begin
			gen_q <= gen_in;
			planes_q <= plane_in;
			axes_q <= axis_in;
			present_q <= present_w;
		end
	end

	// decode outcome and command counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			kind_q <= CMD_BAD;
			last_ok_q <= 1'b0;
			acc_q <= 16'h0000;
			rej_q <= 16'h0000;
		end
		else if (decode_done)
		begin
			kind_q <= kind_w;
			last_ok_q <= kind_w != CMD_BAD;
			if (kind_w == CMD_BAD)
				rej_q <= rej_q + 16'h1;
			else
				acc_q <= acc_q + 16'h1;
		end
	end
	// apb decode: one wait-free access phase after each setup
	wire apb_setup = psel & ~penable;
	wire apb_access = psel & penable & pready_q;
	wire hit_ctrl = paddr == REG_CTRL;
	wire hit_any = hit_ctrl || paddr == REG_STATUS || paddr == REG_COUNT || paddr == REG_GEOMETRY;
	wire wr_ctrl = apb_access & pwrite & hit_ctrl;
	wire [31:0] ctrl_rd = 32'({echo_q, 5'h00, mask_q}) & 32'h0001_07FF;
	wire [31:0] stat_rd = 32'({last_ok_q, echo_q, state_q != ST_RX});
	wire [31:0] rd_mux = hit_ctrl ? ctrl_rd :
		(paddr == REG_STATUS) ? stat_rd :
		(paddr == REG_COUNT) ? {rej_q, acc_q} :
		(paddr == REG_GEOMETRY) ? geo_word : 32'h0000_0000;

	// apb answer registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= apb_setup;
			prdata_q <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr_q <= apb_setup & ~hit_any;
		end
	end

	// control register; echo command overrides a same-cycle write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_q <= CTRL_MASK_RESET;
			echo_q <= CTRL_ECHO_RESET;
		end
		else
		begin
			if (wr_ctrl && pstrb[0])
				mask_q[7:0] <= pwdata[7:0];
			if (wr_ctrl && pstrb[1])
				mask_q[10:8] <= pwdata[10:8];
			if (decode_done && kind_w == CMD_ECHO)
				echo_q <= arg_q == CH_1;
			else if (wr_ctrl && pstrb[2])
				echo_q <= pwdata[CTRL_ECHO_BIT];
		end
	end

	// outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign rx_ready = rx_ready_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign tx_port = tx_port_q;

endmodule : status_record_and_reply_framer

// ==== logic/frame_pkg.sv ====
package frame_pkg;

	// apb register map
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
	localparam logic [APB_AW-1:0] REG_COUNT = 12'h008;
	localparam logic [APB_AW-1:0] REG_GEOMETRY = 12'h00C;
	localparam logic [10:0] CTRL_MASK_RESET = 11'h7FF;
	localparam int CTRL_ECHO_BIT = 16;
	localparam logic CTRL_ECHO_RESET = 1'b0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ECHO_BIT = 1;
	localparam int STAT_OK_BIT = 2;

	// record header layout
	localparam int HDR_BYTES = 4;
	localparam int HDR_MARK_BIT = 15;
	localparam int HDR_S_BIT = 8;
	localparam int HDR_T_BIT = 9;
	localparam int HDR_I_BIT = 10;
	localparam int NUM_BLOCKS = 11;

	// axis count and block sizes in bytes
	localparam int AXIS_MAX = 8;
	localparam int GEN_BYTES = 2;
	localparam int PLANE_BYTES = 8;
	localparam int AXIS_BYTES = 14;
	localparam int GEO_BYTES = 4;

	// general status bit positions
	localparam int GS_RUN_BIT = 7;
	localparam int GS_WAIT_BIT = 2;
	localparam int GS_TRACE_BIT = 1;
	localparam int GS_ECHO_BIT = 0;

	// velocity and torque scaling
	localparam int VEL_SCALE_SHIFT = 6;
	localparam logic signed [17:0] TORQUE_MAX = 18'sh07FFF;
	localparam logic signed [17:0] TORQUE_MIN = 18'sh38001;

	// ascii characters
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_QMARK = 8'h3F;
	localparam logic [7:0] CH_0 = 8'h30;
	localparam logic [7:0] CH_1 = 8'h31;
	localparam logic [7:0] CH_E = 8'h45;
	localparam logic [7:0] CH_O = 8'h4F;
	localparam logic [7:0] CH_Q = 8'h51;
	localparam logic [7:0] CH_R = 8'h52;
	localparam logic [7:0] CH_Z = 8'h5A;

	// command decode time
	localparam int CLK_PERIOD_NS = 4;
	localparam int DECODE_TIME_NS = 500000;
	localparam int DECODE_CYCLES_DEF = DECODE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {CMD_BAD, CMD_RECORD, CMD_GEOMETRY, CMD_ECHO} cmd_kind_t;

	// general controller state
	typedef struct packed {
		logic program_running;
		logic waiting_input;
		logic trace_on;
		logic [7:0] error_code;
	} gen_in_t;

	// coordinated plane state
	typedef struct packed {
		logic [15:0] seg_count;
		logic move_busy;
		logic slewing;
		logic stopping;
		logic final_decel;
		logic signed [31:0] distance;
	} plane_in_t;

	// per-axis state
	typedef struct packed {
		logic move_busy;
		logic abs_or_rel;
		logic abs_only;
		logic find_edge;
		logic home_busy;
		logic home_ph1_done;
		logic home_ph2_done;
		logic coord_mode;
		logic neg_dir;
		logic contour;
		logic slewing;
		logic stopping;
		logic final_decel;
		logic latch_armed;
		logic oe_armed;
		logic motor_off;
		logic latch_seen;
		logic latch_level;
		logic fwd_limit;
		logic rev_limit;
		logic home_level;
		logic stepper_jumper;
		logic [7:0] stopcode;
		logic signed [31:0] motor_pos;
		logic signed [31:0] vel_report;
		logic signed [17:0] torque_raw;
	} axis_in_t;

endpackage : frame_pkg

// ==== logic/record_byte_source.sv ====
`timescale 1ns/1ps
module record_byte_source (
	// snapshot of controller state
	input frame_pkg::gen_in_t gen,
	input frame_pkg::plane_in_t [1:0] planes,
	input frame_pkg::axis_in_t [frame_pkg::AXIS_MAX-1:0] axes,
	input logic [10:0] present,
	input logic echo_on,
	// byte select
	input logic [15:0] index,
	output logic [7:0] rec_byte,
	output logic [15:0] rec_len
);
	import frame_pkg::*;

	localparam int BLK_W = AXIS_BYTES * 8;

	// clip raw torque to the symmetric range
	function automatic logic [15:0] torque_clip(input logic signed [17:0] t);
		logic [15:0] r;
		r = t[15:0];
		if (t > TORQUE_MAX)
			r = TORQUE_MAX[15:0];
		else if (t < TORQUE_MIN)
			r = TORQUE_MIN[15:0];
		return r;
	endfunction : torque_clip

	// header presence bit that belongs to block k
	function automatic int pres_bit(input int k);
		int b;
		b = k - 3;
		if (k == 0)
			b = HDR_I_BIT;
		else if (k == 1)
			b = HDR_S_BIT;
		else if (k == 2)
			b = HDR_T_BIT;
		return b;
	endfunction : pres_bit

	logic [BLK_W-1:0] blk [NUM_BLOCKS];
	logic [7:0] blk_size [NUM_BLOCKS];
	logic [7:0] gen_status;
	logic [15:0] hdr_word;
	logic [31:0] hdr_bytes;

	// general block: error code then status byte
	always_comb
	begin
		gen_status = 8'h00;
		gen_status[GS_RUN_BIT] = gen.program_running;
		gen_status[GS_WAIT_BIT] = gen.waiting_input;
		gen_status[GS_TRACE_BIT] = gen.trace_on;
		gen_status[GS_ECHO_BIT] = echo_on;
	end

	assign blk[0] = BLK_W'({gen_status, gen.error_code});
	assign blk_size[0] = 8'(GEN_BYTES);

	// plane blocks: segment count, status, distance, all little endian
	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_plane
			logic [15:0] pst;
			assign pst = {planes[p].move_busy, 7'h00, 2'h0, planes[p].slewing,
				planes[p].stopping, planes[p].final_decel, 3'h0};
			assign blk[1+p] = BLK_W'({planes[p].distance, pst, planes[p].seg_count});
			assign blk_size[1+p] = 8'(PLANE_BYTES);
		end
	endgenerate

	// axis blocks: status, switches, stopcode, position, velocity, torque
	genvar a;
	generate
		for (a = 0; a < AXIS_MAX; a++)
		begin : g_axis
			logic [15:0] ast;
			logic [7:0] sw;
			logic [31:0] vel;
			assign ast = {axes[a].move_busy, axes[a].abs_or_rel, axes[a].abs_only,
				axes[a].find_edge, axes[a].home_busy, axes[a].home_ph1_done,
				axes[a].home_ph2_done, axes[a].coord_mode,
				axes[a].neg_dir, axes[a].contour, axes[a].slewing, axes[a].stopping,
				axes[a].final_decel, axes[a].latch_armed, axes[a].oe_armed,
				axes[a].motor_off};
			assign sw = {axes[a].latch_seen, axes[a].latch_level, 2'h0,
				axes[a].fwd_limit, axes[a].rev_limit,
				axes[a].home_level,
				axes[a].stepper_jumper};
			assign vel = axes[a].vel_report <<< VEL_SCALE_SHIFT;
			assign blk[3+a] = {torque_clip(axes[a].torque_raw), vel, axes[a].motor_pos,
				axes[a].stopcode, sw, ast};
			assign blk_size[3+a] = 8'(AXIS_BYTES);
		end
	endgenerate

	// header: presence word then length, each low byte first
	assign hdr_word = {1'b1, 4'h0, present};
	assign hdr_bytes = {rec_len[15:8], rec_len[7:0], hdr_word[15:8], hdr_word[7:0]};

	// total length: header plus every present block, kept apart from the byte walk
	always_comb
	begin
		rec_len = 16'(HDR_BYTES);
		for (int k = 0; k < NUM_BLOCKS; k++)
			if (present[pres_bit(k)])
				rec_len = rec_len + 16'(blk_size[k]);
	end

	// walk the present blocks to find the selected byte
	always_comb
	begin
		logic [15:0] base;
		logic [15:0] off;
		base = 16'(HDR_BYTES);
		off = 16'h0000;
		rec_byte = 8'h00;
		if (index < 16'(HDR_BYTES))
			rec_byte = hdr_bytes[8*index[1:0] +: 8];
		for (int k = 0; k < NUM_BLOCKS; k++)
		begin
			if (present[pres_bit(k)])
			begin
				off = index - base;
				if (index >= base && off < 16'(blk_size[k]))
					rec_byte = blk[k][8*off[3:0] +: 8];
				base = base + 16'(blk_size[k]);
			end
		end
	end

endmodule : record_byte_source

// ==== verification/frame_chk.sv ====
`timescale 1ns/1ps
module frame_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb answer
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// command and reply bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_port,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_port,
	input wire logic tx_ready
);
	import frame_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic port_q;
	// handshakes seen at the ports
	wire rx_take = rx_valid && rx_ready;
	wire term_take = rx_take && (rx_data == CH_CR || rx_data == CH_SEMI);
	wire tx_take = tx_valid && tx_ready;
	// port of the last byte taken, the reply must go back there
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			port_q <= 1'h0;
		else if (rx_take)
			port_q <= rx_port;
	term_busy_a: assert property (term_take |=> !rx_ready [*4])
		else $error("byte taken during decode");
	reply_due_a: assert property (term_take |-> ##[1:60] tx_valid)
		else $error("no reply after terminator");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_port))
		else $error("reply byte changed before taken");
	tx_port_a: assert property (tx_valid |-> tx_port == port_q)
		else $error("reply on wrong port");
	colon_close_a: assert property (tx_take && tx_data == CH_CR ##1 tx_take && tx_data == CH_LF
		|-> ##[1:2] (tx_valid && tx_data == CH_COLON))
		else $error("no colon after line end");
	rx_quiet_a: assert property (tx_valid |-> !rx_ready)
		else $error("input open while replying");
	echo_byte_a: assert property (rx_take |=> !tx_valid
		|| (tx_data == $past(rx_data) && tx_port == $past(rx_port)))
		else $error("echo differs from byte taken");
	err_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without answer");
	ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle");
endmodule : frame_chk
bind status_record_and_reply_framer frame_chk frame_chk_i (.pclk, .presetn, .psel, .penable,
	.prdata, .pready, .pslverr, .rx_valid, .rx_data, .rx_port, .rx_ready, .tx_valid, .tx_data,
	.tx_port, .tx_ready);

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic pclk,
	// command bytes to the block
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_port,
	input wire logic rx_ready,
	// reply bytes from the block
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_port,
	output logic tx_ready
);
	logic slow = 1'h0;
	logic [8:0] got[$];
	// idle lines at time zero
	initial
	begin
		rx_valid = 1'h0;
		rx_data = 8'h00;
		rx_port = 1'h0;
		tx_ready = 1'h1;
	end
	// collect replies; a slow host stalls every other cycle
	always @(posedge pclk)
	begin
		if (tx_valid && tx_ready)
			got.push_back({tx_port, tx_data});
		tx_ready <= slow ? ~tx_ready : 1'h1;
	end
	// one byte held until taken, data scrambled once released
	task send_byte(input logic [7:0] b, input logic p);
		@(posedge pclk);
		rx_valid <= 1'h1;
		rx_data <= b;
		rx_port <= p;
		do @(posedge pclk); while (rx_ready !== 1'h1);
		rx_valid <= 1'h0;
		rx_data <= ~b;
	endtask : send_byte
	// a command always closes with a terminator
	task send_cmd(input string s, input logic [7:0] term, input logic p);
		foreach (s[i])
			send_byte(s[i], p);
		send_byte(term, p);
	endtask : send_cmd
endmodule : host_model

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
	import frame_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic pready, pslverr, rx_valid, rx_port, rx_ready, tx_valid, tx_port, tx_ready;
	logic [7:0] rx_data, tx_data;
	gen_in_t gen_in;
	plane_in_t [1:0] plane_in;
	axis_in_t [AXIS_MAX-1:0] axis_in;
	int n_fail = 0;
	int compares = 0;
	logic [8:0] exp[$];
	status_record_and_reply_framer #(.NUM_AXES(8), .DECODE_CYCLES(4))
		status_record_and_reply_framer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .gen_in, .plane_in, .axis_in, .rx_valid,
		.rx_data, .rx_port, .rx_ready, .tx_valid, .tx_data, .tx_port, .tx_ready);
	host_model host_model_i (.pclk, .rx_valid, .rx_data, .rx_port, .rx_ready, .tx_valid,
		.tx_data, .tx_port, .tx_ready);
	// 250 MHz clock
	initial
	begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	task check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task final_report;
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// one apb transfer, held until pready is sampled
	task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// expected reply bytes, low byte first
	task put(input logic [31:0] v, input int n, input logic p);
		for (int i = 0; i < n; i++)
			exp.push_back({p, v[8*i +: 8]});
	endtask : put
	// wait for the whole reply before the next command, then compare
	task expect_reply;
		for (int k = 0; k < 2000 && host_model_i.got.size() < exp.size(); k++)
			@(posedge pclk);
		repeat (4) @(posedge pclk);
		check(host_model_i.got.size(), exp.size());
		foreach (exp[i])
			check(host_model_i.got[i], exp[i]);
		host_model_i.got.delete();
		exp.delete();
	endtask : expect_reply
	task exp_axis(input logic [15:0] tq);
		put(32'h0000_A5C3, 2, 1'h0);
		put(32'h0000_3C8B, 2, 1'h0);
		put(32'h1234_5678, 4, 1'h0);
		put(32'h0040_80C0, 4, 1'h0);
		put({16'h0, tq}, 2, 1'h0);
		put({8'h00, CH_COLON, CH_LF, CH_CR}, 3, 1'h0);
	endtask : exp_axis
	task t_regs;
		apb(1'h0, REG_CTRL, 32'h0);
		check(rd, 32'h0000_07FF);
		apb(1'h1, REG_GEOMETRY, 32'hFFFF_FFFF);
		apb(1'h0, REG_GEOMETRY, 32'h0);
		check(rd, 32'h0E08_0208);
		apb(1'h0, 12'h010, 32'h0);
		check(rd, 32'h0000_0000);
		check({31'h0000_0000, err}, 32'h0000_0001);
	endtask : t_regs
	task t_geom;
		host_model_i.slow <= 1'h1;
		host_model_i.send_cmd("QZ", CH_CR, 1'h1);
		put(32'h0E08_0208, 4, 1'h1);
		put({8'h00, CH_COLON, CH_LF, CH_CR}, 3, 1'h1);
		expect_reply;
		host_model_i.slow <= 1'h0;
	endtask : t_geom
	task t_echo;
		host_model_i.send_cmd("XY", CH_SEMI, 1'h0);
		put({24'h0, CH_QMARK}, 1, 1'h0);
		expect_reply;
		host_model_i.send_cmd("EO 1", CH_CR, 1'h0);
		put({24'h0, CH_COLON}, 1, 1'h0);
		expect_reply;
		apb(1'h0, REG_STATUS, 32'h0);
		check(rd, 32'h0000_0006);
		host_model_i.send_cmd("QZ", CH_SEMI, 1'h0);
		put({8'h00, CH_SEMI, CH_Z, CH_Q}, 3, 1'h0);
		put(32'h0E08_0208, 4, 1'h0);
		put({8'h00, CH_COLON, CH_LF, CH_CR}, 3, 1'h0);
		expect_reply;
		host_model_i.send_cmd("EO0", CH_SEMI, 1'h0);
		put({CH_SEMI, CH_0, CH_O, CH_E}, 4, 1'h0);
		put({24'h0, CH_COLON}, 1, 1'h0);
		expect_reply;
	endtask : t_echo
	task t_rec1;
		apb(1'h1, REG_CTRL, 32'h0001_0401);
		host_model_i.send_cmd("QR", CH_CR, 1'h0);
		put({8'h00, CH_CR, CH_R, CH_Q}, 3, 1'h0);
		put(32'h0014_8401, 4, 1'h0);
		put(32'h0000_835A, 2, 1'h0);
		exp_axis(16'h7FFF);
		expect_reply;
	endtask : t_rec1
	task t_rec2;
		apb(1'h1, REG_CTRL, 32'h0000_0601);
		gen_in <= {1'h0, 1'h1, 1'h0, 8'h5A};
		axis_in[0].torque_raw <= 18'h20000;
		host_model_i.send_cmd("QR", CH_SEMI, 1'h0);
		put(32'h001C_8601, 4, 1'h0);
		put(32'h0000_045A, 2, 1'h0);
		put(32'h8018_0102, 4, 1'h0);
		put(32'hFFFF_FFFE, 4, 1'h0);
		exp_axis(16'h8001);
		expect_reply;
		apb(1'h0, REG_COUNT, 32'h0);
		check(rd, 32'h0001_0006);
	endtask : t_rec2
	// reset, then the scenarios in turn
	initial
	begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		gen_in = {1'h1, 1'h0, 1'h1, 8'h5A};
		plane_in = {{16'h0102, 4'hB, 32'hFFFF_FFFE}, {52{1'h1}}};
		axis_in = '1;
		axis_in[0] = {16'hA5C3, 6'h2B, 8'h3C, 32'h1234_5678, 32'h0001_0203, 18'h1FFFF};
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		t_regs;
		t_geom;
		t_echo;
		t_rec1;
		t_rec2;
		final_report;
	end
	// cut a hang short well past the expected run length
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report;
	end
endmodule : tb
